// >>> design/pies_top.sv
// Purpose: priority interrupt acknowledge, routine exit and single-step
// Assumes: processor drives pulse time, phase bits and decoded opcode
// Notes: request capture timing kept minimal; vector transfer is outside
// Notes on behaviour
// (R1) acknowledge T22-T17 when interrupt set, not end
// (R2) later higher request waits for branch-and-mark end
// (R3) routine exit clears active request and in-service
// (R4) indirect return restores saved program counter
// (R5) waiting channel recognised only at return's end
// (R6) any channel may be single-instruction
// (R7) single-instruction signal ORs designated in-service bits
// (R8) single-instruction sets indirect flag, T24, phases one/three
// (R9) single-instruction exit T22-T17, phase one, no steal
// (R10) exit on indirect unconditional branch in phase zero
// (R11) exit clears only highest in-service channel
// (R12) acknowledge sets in-service of top pending channel
// (R13) single-instruction set is a build parameter
`timescale 1ns/1ps
`default_nettype none
module pies_top import pies_pkg::*; #(
  parameter int NCH = PIES_NCH_DEF,
  parameter logic [NCH-1:0] SINGLE_MASK = '0 // R13
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // external request lines
  input wire logic [NCH-1:0] irq_lines,
  // processor timing and phase
  input wire logic [4:0] pulse_time,
  input wire logic phase_bit_one,
  input wire logic phase_bit_two,
  input wire logic phase_bit_three,
  input wire logic int_flag,
  input wire logic memory_steal_flag,
  input wire logic indirect_addr_flag,
  input wire logic [5:0] opcode,
  // program counter handling
  input wire logic [13:0] pc_in,
  input wire logic pc_load_int,
  // outputs
  output logic irq_to_cpu,
  output logic ack_pulse,
  output logic routine_exit,
  output logic single_instr_irq,
  output logic set_indirect,
  output logic pc_inhibit,
  output logic [13:0] pc_restore,
  output logic [NCH-1:0] channel_pending,
  output logic [NCH-1:0] channel_in_service
);
  // elaboration guard: the priority loops assume a small channel count
  if (NCH < 1 || NCH > 16) begin : g_nch_check
    $error("NCH must be 1..16");
  end

  logic [NCH-1:0] irq_meta, irq_sync;
  logic in_win, at_t24, phase_zero, exit_raw, next_set_ind;
  logic exit_seen, ack_seen, next_exit_seen, next_ack_seen, exit_fire, ack_fire;
  logic [13:0] next_pc;
  logic [2:0] phase;

  ////////////////////////////////////////////////////////////////
  // two-stage sync of asynchronous request lines
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      irq_meta <= irq_lines;
      irq_sync <= irq_meta;
    end
  end

  // pulse window decode
  assign in_win = (pulse_time <= PIES_T_WIN_HI) && (pulse_time >= PIES_T_WIN_LO);
  assign at_t24 = (pulse_time == PIES_T_INDIR);
  assign phase = {phase_bit_one, phase_bit_two, phase_bit_three};
  assign phase_zero = (phase == PIES_PH_ZERO);

  // acknowledge not gated by the steal flag, so a vectored
  // branch-and-mark of a lower channel always runs first
  assign ack_pulse = int_flag && !phase_bit_one && in_win; // R1 R2

  // single-instruction flag from designated in-service bits
  assign single_instr_irq = |(channel_in_service & SINGLE_MASK); // R6 R7 R13

  // exit: indirect unconditional branch, or single-instruction
  assign exit_raw = (phase_zero && indirect_addr_flag && opcode == PIES_OP_BRANCH_UNCOND && in_win) // R10
    || (single_instr_irq && !memory_steal_flag && phase_bit_one && in_win); // R9
  assign routine_exit = exit_raw;

  // pending higher channel stays queued until the next end cycle,
  // which is the return's own end, so restored pc is what it saves
  assign pc_inhibit = set_indirect; // R8

  ////////////////////////////////////////////////////////////////
  // exit and acknowledge stand for the whole six-pulse window but
  // act as clocking terms; only their first cycle moves channel
  // state, else one return would unwind every nested routine
  always_comb begin
    next_exit_seen = routine_exit;
    next_ack_seen = ack_pulse;
    exit_fire = routine_exit && !exit_seen; // R11
    ack_fire = ack_pulse && !ack_seen; // R12
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      exit_seen <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      exit_seen <= next_exit_seen;
      ack_seen <= next_ack_seen;
    end
  end

  ////////////////////////////////////////////////////////////////
  // indirect flag set and saved program counter
  always_comb begin
    next_set_ind = 1'b0;
    if (single_instr_irq && at_t24 && phase_bit_one && phase_bit_three) begin
      next_set_ind = 1'b1; // R8
    end
    next_pc = pc_restore;
    if (pc_load_int && !single_instr_irq) begin
      next_pc = pc_in; // R4 R5
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      set_indirect <= 1'b0;
      pc_restore <= '0;
    end else begin
      set_indirect <= next_set_ind;
      pc_restore <= next_pc;
    end
  end

  pies_chan #(.NCH(NCH)) u_chan (
    .clk(clk),
    .nrst(nrst),
    .req_sync(irq_sync),
    .req_window(in_win),
    .ack_pulse(ack_fire),
    .routine_exit(exit_fire),
    .channel_pending(channel_pending),
    .channel_in_service(channel_in_service),
    .irq_to_cpu(irq_to_cpu)
  );

  ////////////////////////////////////////////////////////////////
  sequence s_si_t24;
    single_instr_irq && at_t24 && phase_bit_one && phase_bit_three;
  endsequence
  property p_ack_window;
    @(posedge clk) disable iff (!nrst) ack_pulse |-> (in_win && int_flag && !phase_bit_one);
  endproperty
  a_ack_window: assert property (p_ack_window) else $error("ack outside window"); // R1
  property p_ack_steal;
    @(posedge clk) disable iff (!nrst) (int_flag && !phase_bit_one && in_win && memory_steal_flag) |-> ack_pulse;
  endproperty
  a_ack_steal: assert property (p_ack_steal) else $error("ack gated by steal"); // R2
  property p_si_exit;
    @(posedge clk) disable iff (!nrst)
      (single_instr_irq && !memory_steal_flag && phase_bit_one && in_win) |-> routine_exit;
  endproperty
  a_si_exit: assert property (p_si_exit) else $error("single exit missing"); // R9
  property p_return_exit;
    @(posedge clk) disable iff (!nrst)
      (phase_zero && indirect_addr_flag && opcode == PIES_OP_BRANCH_UNCOND && in_win) |-> routine_exit;
  endproperty
  a_return_exit: assert property (p_return_exit) else $error("return exit missing"); // R10
  property p_exit_clear;
    @(posedge clk) disable iff (!nrst)
      (exit_fire && !ack_fire && channel_in_service != '0) |=> $countones(channel_in_service)
        == $countones($past(channel_in_service)) - 1;
  endproperty
  a_exit_clear: assert property (p_exit_clear) else $error("exit cleared wrong count"); // R3
  property p_ind;
    @(posedge clk) disable iff (!nrst) s_si_t24 |=> set_indirect && pc_inhibit;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect flag not set"); // R8
  property p_si_or;
    @(posedge clk) disable iff (!nrst) single_instr_irq == |(channel_in_service & SINGLE_MASK);
  endproperty
  a_si_or: assert property (p_si_or) else $error("single flag mismatch"); // R7
  property p_ack_sets;
    @(posedge clk) disable iff (!nrst)
      (ack_fire && irq_to_cpu && !exit_fire) |=> $countones(channel_in_service)
        == $countones($past(channel_in_service)) + 1;
  endproperty
  a_ack_sets: assert property (p_ack_sets) else $error("ack did not set service"); // R12
  property p_pc_hold;
    @(posedge clk) disable iff (!nrst) (!pc_load_int) |=> pc_restore == $past(pc_restore);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("saved pc moved"); // R4
  // held terms and refused events leave the channel state alone
  property p_exit_hold;
    @(posedge clk) disable iff (!nrst)
      (routine_exit && !exit_fire && !ack_fire) |=> channel_in_service == $past(channel_in_service);
  endproperty
  a_exit_hold: assert property (p_exit_hold) else $error("held exit cleared again"); // R11
  property p_exit_none;
    @(posedge clk) disable iff (!nrst)
      (exit_fire && !ack_fire && channel_in_service == '0) |=> channel_in_service == '0;
  endproperty
  a_exit_none: assert property (p_exit_none) else $error("exit with nothing in service moved state"); // R3
  property p_serv_pend;
    @(posedge clk) disable iff (!nrst) (channel_in_service & ~channel_pending) == '0;
  endproperty
  a_serv_pend: assert property (p_serv_pend) else $error("in service without request"); // R3
  property p_ind_off;
    @(posedge clk) disable iff (!nrst)
      !(single_instr_irq && at_t24 && phase_bit_one && phase_bit_three) |=> !pc_inhibit;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("pc inhibit without cause"); // R8
  property p_si_pc;
    @(posedge clk) disable iff (!nrst) single_instr_irq |=> pc_restore == $past(pc_restore);
  endproperty
  a_si_pc: assert property (p_si_pc) else $error("single step moved saved pc"); // R6
endmodule
`default_nettype wire

// >>> design/pies_pkg.sv
// Purpose: constants for the priority interrupt exit and single-step block
// Assumes: pulse times counted 0..24, phase code in three phase bits
// Notes: shared by the top module and the channel priority module
package pies_pkg;
  // pulse-time window bounds; the window runs from 22 down to 17
  localparam logic [4:0] PIES_T_WIN_HI = 5'h16;
  localparam logic [4:0] PIES_T_WIN_LO = 5'h11;
  localparam logic [4:0] PIES_T_INDIR = 5'h18;
  localparam logic [4:0] PIES_T_LAST = 5'h18;
  // phase codes
  localparam logic [2:0] PIES_PH_ZERO = 3'h0;
  localparam logic [2:0] PIES_PH_FOUR = 3'h4;
  localparam logic [2:0] PIES_PH_SIX = 3'h6;
  // opcodes
  localparam logic [5:0] PIES_OP_BRANCH_UNCOND = 6'h01;
  localparam logic [5:0] PIES_OP_BRANCH_MARK = 6'h23;
  // reset values
  localparam logic [4:0] PIES_PT_RST = 5'h00;
  localparam int PIES_NCH_DEF = 4;
  typedef enum logic [2:0] {
    PIES_ST_IDLE = 3'b001,
    PIES_ST_ACK = 3'b010,
    PIES_ST_SERV = 3'b100
  } pies_state_t;
endpackage

// >>> design/pies_chan.sv
// Purpose: channel request and in-service flip-flops with priority
// Assumes: channel 0 has the highest priority
// Notes: one routine exit clears only the top in-service channel
`timescale 1ns/1ps
`default_nettype none
module pies_chan import pies_pkg::*; #(
  parameter int NCH = PIES_NCH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events
  input wire logic [NCH-1:0] req_sync,
  input wire logic req_window,
  input wire logic ack_pulse,
  input wire logic routine_exit,
  // state
  output logic [NCH-1:0] channel_pending,
  output logic [NCH-1:0] channel_in_service,
  output logic irq_to_cpu
);
  logic [NCH-1:0] next_pending, next_serv, win_req, top_serv;

  // lowest set bit wins: highest priority
  function automatic logic [NCH-1:0] first_one(input logic [NCH-1:0] v);
    logic [NCH-1:0] r;
    logic found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (v[i] && !found) begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // winner: pending channel above which nothing pends or serves
  always_comb begin
    win_req = '0;
    for (int i = 0; i < NCH; i++) begin
      if (channel_pending[i] && !channel_in_service[i]) begin
        win_req[i] = 1'b1;
        for (int j = 0; j < i; j++) begin
          if (channel_pending[j]) begin
            win_req[i] = 1'b0;
          end
        end
      end
    end
    top_serv = first_one(channel_in_service);
  end

  assign irq_to_cpu = |win_req;

  ////////////////////////////////////////////////////////////////
  // set wins over exit clear for incoming requests
  always_comb begin
    next_pending = channel_pending;
    next_serv = channel_in_service;
    if (routine_exit) begin
      next_pending = next_pending & ~top_serv; // R3 R11
      next_serv = next_serv & ~top_serv; // R3 R11
    end
    if (ack_pulse) begin
      next_serv = next_serv | win_req; // R12
    end
    if (req_window) begin
      next_pending = next_pending | req_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      channel_pending <= '0;
      channel_in_service <= '0;
    end else begin
      channel_pending <= next_pending;
      channel_in_service <= next_serv;
    end
  end

  property p_exit_top;
    @(posedge clk) disable iff (!nrst)
      routine_exit && !ack_pulse && (channel_in_service != '0)
      |=> (channel_in_service == ($past(channel_in_service) & ~$past(top_serv)));
  endproperty
  a_exit_top: assert property (p_exit_top) else $error("exit did not clear top channel only"); // R11
endmodule
`default_nettype wire

// >>> verif/pies_cpu_model.sv
// Purpose: processor pulse counter and interrupt flip-flop for the bench
// Assumes: an end cycle is shown by phase bit one high
// Notes: the interrupt flip-flop only moves at pulse time 10
`timescale 1ns/1ps
`default_nettype none
module pies_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // from the block and phase control
  input wire logic irq_to_cpu,
  input wire logic phase_bit_one,
  // to the block
  output logic [4:0] pulse_time,
  output logic int_flag
);
  ////////////////////////////////////////
  // pulse count wraps after 24; flag taken at an end cycle, dropped after the acknowledge cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_time <= 5'h00;
      int_flag <= 1'b0;
    end else begin
      pulse_time <= (pulse_time == 5'h18) ? 5'h00 : pulse_time + 5'h01;
      if (pulse_time == 5'h0a && !int_flag && irq_to_cpu && phase_bit_one) begin
        int_flag <= 1'b1;
      end else if (pulse_time == 5'h0a && int_flag && !phase_bit_one) begin
        int_flag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench for the interrupt exit and single-step block
// Assumes: channel 2 is built as the only single-instruction channel
// Notes: combinational terms are checked every cycle at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] MASK = 4'h4;
  logic clk, nrst, ph1, ph2, ph3, stl, ind, pcl, xit, irqc, ack, ex, sgl, si, pci, exp_si, intf;
  logic [3:0] irq, pend, insv, m;
  logic [5:0] opc;
  logic [4:0] pt;
  logic [13:0] pc, pcr, exp_pc;
  logic [31:0] seed = 32'h9ad2f4c9;
  int n_errors, tests_run;
  ////////////////////////////////////////
  // block under test and processor model
  pies_top #(.NCH(4), .SINGLE_MASK(MASK)) u_pies_top (.clk(clk), .nrst(nrst), .irq_lines(irq),
    .pulse_time(pt), .phase_bit_one(ph1), .phase_bit_two(ph2), .phase_bit_three(ph3), .int_flag(intf),
    .memory_steal_flag(stl), .indirect_addr_flag(ind), .opcode(opc), .pc_in(pc), .pc_load_int(pcl),
    .irq_to_cpu(irqc), .ack_pulse(ack), .routine_exit(ex), .single_instr_irq(sgl), .set_indirect(si),
    .pc_inhibit(pci), .pc_restore(pcr), .channel_pending(pend), .channel_in_service(insv));
  pies_cpu_model u_pies_cpu_model (.clk(clk), .nrst(nrst), .irq_to_cpu(irqc), .phase_bit_one(ph1),
    .pulse_time(pt), .int_flag(intf));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // lowest set bit is the highest priority channel
  function automatic logic [3:0] top(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction
  function automatic logic win(input logic [4:0] p);
    return p >= 5'h11 && p <= 5'h16;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_pend(input logic [3:0] w);
    for (int i = 0; i < 80 && pend !== w; i++)
      @(posedge clk);
  endtask
  // end cycle until the flag is taken, then a plain cycle for the acknowledge
  task automatic serve();
    ph1 <= 1'b1;
    for (int i = 0; i < 80 && !intf; i++)
      @(posedge clk);
    ph1 <= 1'b0;
    for (int i = 0; i < 80 && intf; i++)
      @(posedge clk);
  endtask
  // one whole pulse period of indirect branch in phase zero, so exactly one window
  task automatic exit_once();
    while (pt !== 5'h17)
      @(posedge clk);
    xit <= 1'b1;
    @(posedge clk);
    ind <= 1'b1;
    {ph1, ph2, ph3} <= 3'b000;
    repeat (25) @(posedge clk);
    ind <= 1'b0;
    xit <= 1'b0;
  endtask
  ////////////////////////////////////////
  // noise on steal, pc load and opcode; seed moves by nonblocking so readers never race it
  always @(posedge clk) begin
    seed <= xs(seed);
    stl <= seed[0];
    pcl <= seed[1];
    pc <= seed[15:2];
    opc <= xit ? 6'h01 : seed[21:16];
  end
  // every cycle: terms against their causes, registered outputs against last cycle
  always @(negedge clk) begin
    if (!nrst) begin
      exp_si = 1'b0;
      exp_pc = 14'h0000;
    end else begin
      chk(ack, intf & ~ph1 & win(pt));
      chk(ex, win(pt) & ((~ph1 & ~ph2 & ~ph3 & ind & (opc == 6'h01)) | (sgl & ~stl & ph1)));
      chk(sgl, |(insv & MASK));
      chk(si, exp_si);
      chk(pci, exp_si);
      chk(irqc, |(top(pend) & ~insv));
      chk(pcr, exp_pc);
      exp_si = sgl & ph1 & ph3 & (pt == 5'h18);
      if (pcl && !sgl)
        exp_pc = pc;
    end
  end
  initial begin
    {nrst, ph1, ph2, ph3, ind, xit} = 6'h00;
    irq = 4'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({pend, insv}, 8'h00);
    // random request sets served top down; the single channel is kept out here
    repeat (4) begin
      m = seed[3:0] & 4'hb;
      if (m == 4'h0)
        m = 4'h8;
      irq <= m;
      wait_pend(m);
      irq <= 4'h0;
      while (m !== 4'h0) begin
        serve();
        chk(insv, top(m));
        exit_once();
        m = m & ~top(m);
        chk(pend, m);
      end
    end
    $display("test random_requests done");
    // a higher channel breaks into a lower routine; one exit leaves the lower in service
    irq <= 4'h8;
    wait_pend(4'h8);
    irq <= 4'h0;
    serve();
    irq <= 4'h1;
    wait_pend(4'h9);
    irq <= 4'h0;
    serve();
    chk(insv, 4'h9);
    exit_once();
    chk({pend, insv}, 8'h88);
    exit_once();
    chk({pend, insv}, 8'h00);
    $display("test nested done");
    // single-instruction channel ends itself once the steal noise lets it
    irq <= MASK;
    wait_pend(MASK);
    irq <= 4'h0;
    serve();
    chk(sgl, 1'b1);
    ph1 <= 1'b1;
    ph3 <= 1'b1;
    for (int i = 0; i < 200 && insv !== 4'h0; i++)
      @(posedge clk);
    chk({pend, insv}, 8'h00);
    $display("test single_step done");
    complete_run();
  end
  // hang guard, well beyond the thousand or so cycles the tests take
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
